// ---- inc/lmma_pkg.sv ----
// Purpose: shared constants and types of the life monitor block
// Assumes: 40 MHz clock, byte addresses on the register port
// Notes: life values are whole percent, 0 to 100
package lmma_pkg;
    localparam int CLK_MHZ = 40;
    localparam int LIFE_W = 7;
    localparam int NPART = 4;
    localparam logic [6:0] LIFE_FULL = 7'h64;
    localparam logic [6:0] LIFE_WARN = 7'h0A;
    localparam logic [11:0] WARN_CODE = 12'h09B0;
    // trace sample period in microseconds and in clock cycles
    localparam int SAMPLE_US = 100;
    localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int TRACE_DEPTH = 16;
    localparam int NOUT = 3;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALLOC = 8'h04;
    localparam logic [7:0] OFS_LIFE = 8'h08;
    localparam logic [7:0] OFS_LIFE_LOAD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_TRACE = 8'h18;
    localparam logic [7:0] OFS_TRACE_ADDR = 8'h1C;
    localparam logic [7:0] OFS_TRACE_DATA = 8'h20;
    // field positions
    localparam int CTRL_WEN = 0;
    localparam int CTRL_RESTART = 1;
    localparam int ALLOC_SEL_LSB = 0;
    localparam int ALLOC_COMPAT_LSB = 8;
    localparam int ALLOC_MULTI_LSB = 16;
    localparam int LOAD_IDX_LSB = 8;
    localparam int TRACE_REARM = 0;
    // allocation method select codes
    localparam logic [1:0] SEL_COMPAT = 2'h1;
    localparam logic [1:0] SEL_MULTI = 2'h2;
    // status bits
    localparam int ST_WARN = 0;
    localparam int ST_DUE = 1;
    localparam int ST_TDONE = 2;
    localparam int ST_TREJ = 3;
    localparam int NST = 4;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [3:0] MAP_NONE = 4'h0;

    typedef struct packed {
        logic [15:0] torque_ref;
        logic [15:0] fb_speed;
        logic [15:0] ref_speed;
        logic [15:0] pos_ref_speed;
        logic [15:0] pos_dev;
        logic [15:0] bus_volt;
    } lmma_num_t;

    typedef struct packed {
        lmma_num_t num;
        logic [6:0] onoff;
    } lmma_sample_t;

    typedef enum logic [2:0] {
        TR_ARMED = 3'b001,
        TR_POST = 3'b010,
        TR_HELD = 3'b100
    } lmma_trace_t;
endpackage : lmma_pkg

// ---- hw/lmma_life_cell.sv ----
// Purpose: one wear part life prediction, in percent
// Assumes: dec_i and load_i are one-cycle pulses on mclk_i
// Notes: low_o is updated on the same edge as life_o
module lmma_life_cell #(
    parameter int W = lmma_pkg::LIFE_W
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // update
    input wire logic dec_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // state
    output logic [W-1:0] life_o,
    output logic low_o
);
    logic [W-1:0] next_life;
    logic [W-1:0] clip_val;

    // software loads are clipped to full scale so the value stays a percent
    assign clip_val = (load_val_i > lmma_pkg::LIFE_FULL) ?
                      lmma_pkg::LIFE_FULL : load_val_i;
    // saturate at zero: replacement due stays at 0 percent
    assign next_life = load_i ? clip_val :
                       (dec_i && life_o != '0) ? life_o - 1'b1 :
                       life_o;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            life_o <= lmma_pkg::LIFE_FULL;
            low_o <= 1'b0;
        end else begin
            life_o <= next_life;
            low_o <= next_life <= lmma_pkg::LIFE_WARN;
        end
    end
endmodule : lmma_life_cell

// ---- hw/lmma_trace_mem.sv ----
// Purpose: trace sample store with registered read
// Assumes: one write port, one read port, same clock
// Notes: contents are not reset
module lmma_trace_mem #(
    parameter int DW = $bits(lmma_pkg::lmma_sample_t),
    parameter int DEPTH = lmma_pkg::TRACE_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    // clock
    input wire logic mclk_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : lmma_trace_mem

// ---- hw/lmma_top.sv ----
// Purpose: life monitor, maintenance warning and due output, alarm trace
// Assumes: status pins are asynchronous and pass two flip-flops
// Notes: the enable takes effect only on a restart command or reset

// What this block does
// - life reads 100 percent when new, falls, reaches 0 when due
// - each life value drops on main power turn-on and servo-off
// - if enabled, raise the maintenance warning code at 10 percent or below
// - warning enable defaults off; a change acts after a restart
// - due output closed while any life is at or below 10 percent
// - due output works even when the warning is disabled
// - due output only when allocated; select 1 compat map, 2 multi-axis map
// - trace keeps samples from before and after the alarm
// - trace holds six numeric quantities and seven on/off states
// - no trace for alarms at power-on or during a running capture
// - no trace for alarms during a utility function
// - no trace for alarms during an external tool's tracing session
module lmma_top #(
    parameter int DEPTH = lmma_pkg::TRACE_DEPTH,
    parameter int SAMPLE_CYC = lmma_pkg::SAMPLE_CYC,
    parameter int NOUT = lmma_pkg::NOUT
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // status pins, asynchronous
    input wire logic main_power_on_state_i,
    input wire logic servo_on_i,
    input wire logic servo_alarm_flag_i,
    input wire logic proportional_control_command_i,
    input wire logic forward_torque_limit_command_i,
    input wire logic reverse_torque_limit_command_i,
    input wire logic gain_select_one_i,
    input wire logic powerup_busy_i,
    input wire logic utility_busy_i,
    input wire logic tool_trace_i,
    // numeric trace data, same clock
    input wire lmma_pkg::lmma_num_t num_i,
    // outputs
    output logic maintenance_warning_o,
    output logic [11:0] maintenance_warning_code_o,
    output logic [NOUT-1:0] maintenance_due_output_o,
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int NS = 10;
    localparam int CW = $clog2(SAMPLE_CYC + 1);

    // two-flop synchronisers; stage one feeds only stage two
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] sync3;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= {main_power_on_state_i, servo_on_i,
                      servo_alarm_flag_i, proportional_control_command_i,
                      forward_torque_limit_command_i,
                      reverse_torque_limit_command_i, gain_select_one_i,
                      powerup_busy_i, utility_busy_i, tool_trace_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    wire pwr_s = sync2[9];
    wire son_s = sync2[8];
    wire alm_s = sync2[7];
    wire powerup_s = sync2[2];
    wire util_s = sync2[1];
    wire tool_s = sync2[0];
    wire pwr_rise = pwr_s && !sync3[9];
    wire son_fall = !son_s && sync3[8];
    wire alm_rise = alm_s && !sync3[7];

    // register decode
    wire wr_ctrl = wr_i && addr_i == lmma_pkg::OFS_CTRL;
    wire wr_alloc = wr_i && addr_i == lmma_pkg::OFS_ALLOC;
    wire wr_load = wr_i && addr_i == lmma_pkg::OFS_LIFE_LOAD;
    wire wr_mask = wr_i && addr_i == lmma_pkg::OFS_MASK;
    wire wr_trace = wr_i && addr_i == lmma_pkg::OFS_TRACE;
    wire wr_taddr = wr_i && addr_i == lmma_pkg::OFS_TRACE_ADDR;
    wire rd_status = rd_i && addr_i == lmma_pkg::OFS_STATUS;
    wire restart = wr_ctrl && wdata_i[lmma_pkg::CTRL_RESTART];

    // configuration registers
    logic wen_cfg;
    logic wen_act;
    logic [1:0] alloc_sel;
    logic [3:0] compat_map;
    logic [3:0] multi_map;
    logic [lmma_pkg::NST-1:0] mask;
    logic [AW+2:0] taddr;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wen_cfg <= 1'b0;
            wen_act <= 1'b0;
            alloc_sel <= 2'h0;
            compat_map <= lmma_pkg::MAP_NONE;
            multi_map <= lmma_pkg::MAP_NONE;
            mask <= lmma_pkg::MASK_RST;
            taddr <= '0;
        end else begin
            if (wr_ctrl) begin
                wen_cfg <= wdata_i[lmma_pkg::CTRL_WEN];
            end
            // stored setting only acts from the next restart
            if (restart) begin
                wen_act <= wr_ctrl ? wdata_i[lmma_pkg::CTRL_WEN] : wen_cfg;
            end
            if (wr_alloc) begin
                alloc_sel <= wdata_i[lmma_pkg::ALLOC_SEL_LSB +: 2];
                compat_map <= wdata_i[lmma_pkg::ALLOC_COMPAT_LSB +: 4];
                multi_map <= wdata_i[lmma_pkg::ALLOC_MULTI_LSB +: 4];
            end
            if (wr_mask) begin
                mask <= wdata_i[lmma_pkg::NST-1:0];
            end
            if (wr_taddr) begin
                taddr <= wdata_i[AW+2:0];
            end
        end
    end

    // life cells
    logic [lmma_pkg::LIFE_W-1:0] life [lmma_pkg::NPART];
    logic [lmma_pkg::NPART-1:0] low;
    wire life_dec = pwr_rise || son_fall;
    wire [1:0] load_idx = wdata_i[lmma_pkg::LOAD_IDX_LSB +: 2];
    for (genvar g = 0; g < lmma_pkg::NPART; g++) begin : g_cell
        lmma_life_cell u_cell (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .dec_i(life_dec),
            .load_i(wr_load && load_idx == 2'(g)),
            .load_val_i(wdata_i[lmma_pkg::LIFE_W-1:0]),
            .life_o(life[g]),
            .low_o(low[g])
        );
    end
    wire any_low = |low;

    // due output allocation
    wire [3:0] sel_map = (alloc_sel == lmma_pkg::SEL_COMPAT) ? compat_map :
                         (alloc_sel == lmma_pkg::SEL_MULTI) ? multi_map :
                         lmma_pkg::MAP_NONE;
    wire alloc = sel_map != lmma_pkg::MAP_NONE && sel_map <= 4'(NOUT);
    logic [NOUT-1:0] next_due;
    always_comb begin
        next_due = '0;
        for (int k = 0; k < NOUT; k++) begin
            // the warning enable plays no part here
            next_due[k] = alloc && any_low && sel_map == 4'(k + 1);
        end
    end
    wire next_warn = wen_act && any_low;

    // trace recorder
    lmma_pkg::lmma_trace_t tr_state;
    lmma_pkg::lmma_trace_t next_tr;
    logic [CW-1:0] tick_cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] trig_ptr;
    logic [AW-1:0] post_cnt;
    wire tick = tick_cnt == '0;
    wire tr_armed = tr_state == lmma_pkg::TR_ARMED;
    wire tr_post = tr_state == lmma_pkg::TR_POST;
    // alarm refused at power-on, during capture, utility or tool trace
    wire inhibit = powerup_s || util_s || tool_s || !tr_armed;
    wire accept = alm_rise && !inhibit;
    wire reject = alm_rise && inhibit;
    wire post_end = tr_post && tick && post_cnt == '0;
    lmma_pkg::lmma_sample_t smp;
    assign smp.num = num_i;
    assign smp.onoff = sync2[9:3];
    always_comb begin
        next_tr = tr_state;
        unique case (tr_state)
            lmma_pkg::TR_ARMED: if (accept) next_tr = lmma_pkg::TR_POST;
            lmma_pkg::TR_POST: if (post_end) next_tr = lmma_pkg::TR_HELD;
            lmma_pkg::TR_HELD: begin
                if (wr_trace && wdata_i[lmma_pkg::TRACE_REARM]) begin
                    next_tr = lmma_pkg::TR_ARMED;
                end
            end
            default: next_tr = lmma_pkg::TR_ARMED;
        endcase
    end
    // half the ring is history before the alarm, half after it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tr_state <= lmma_pkg::TR_ARMED;
            tick_cnt <= '0;
            wp <= '0;
            trig_ptr <= '0;
            post_cnt <= '0;
        end else begin
            tr_state <= next_tr;
            tick_cnt <= tick ? CW'(SAMPLE_CYC - 1) : tick_cnt - 1'b1;
            if (tick && !tr_state[2]) begin
                wp <= wp + 1'b1;
            end
            if (accept) begin
                trig_ptr <= wp;
                post_cnt <= AW'(DEPTH / 2 - 1);
            end else if (tr_post && tick && post_cnt != '0) begin
                post_cnt <= post_cnt - 1'b1;
            end
        end
    end
    lmma_pkg::lmma_sample_t mem_q;
    lmma_trace_mem #(
        .DW($bits(lmma_pkg::lmma_sample_t)),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .mclk_i(mclk_i),
        .we_i(tick && !tr_state[2]),
        .waddr_i(wp),
        .wdata_i(smp),
        // index 0 is the oldest sample: the slot the ring writes next
        .raddr_i(taddr[AW+2:3] + wp),
        .rdata_o(mem_q)
    );
    logic [15:0] tword;
    always_comb begin
        unique case (taddr[2:0])
            3'h0: tword = mem_q.num.torque_ref;
            3'h1: tword = mem_q.num.fb_speed;
            3'h2: tword = mem_q.num.ref_speed;
            3'h3: tword = mem_q.num.pos_ref_speed;
            3'h4: tword = mem_q.num.pos_dev;
            3'h5: tword = mem_q.num.bus_volt;
            3'h6: tword = {9'h000, mem_q.onoff};
            default: tword = 16'h0000;
        endcase
    end

    // sticky status; a new event wins over the clearing read
    logic [lmma_pkg::NST-1:0] status;
    logic warn_q;
    logic due_q;
    wire [lmma_pkg::NST-1:0] ev = {reject, post_end,
                                   |next_due && !due_q,
                                   next_warn && !warn_q};
    wire [lmma_pkg::NST-1:0] next_status =
        (rd_status ? '0 : status) | ev;

    // read mux
    logic [31:0] rmux;
    always_comb begin
        unique case (addr_i)
            lmma_pkg::OFS_CTRL: rmux = {30'h0, wen_act, wen_cfg};
            lmma_pkg::OFS_ALLOC: rmux = {12'h000, multi_map, 4'h0,
                                         compat_map, 6'h00, alloc_sel};
            lmma_pkg::OFS_LIFE: rmux = {1'b0, life[3], 1'b0, life[2],
                                        1'b0, life[1], 1'b0, life[0]};
            lmma_pkg::OFS_STATUS: rmux = {28'h000_0000, status};
            lmma_pkg::OFS_MASK: rmux = {28'h000_0000, mask};
            lmma_pkg::OFS_TRACE: rmux = {8'h00, 8'(trig_ptr),
                                         8'(wp), 5'h00, tr_state};
            lmma_pkg::OFS_TRACE_ADDR: rmux = 32'(taddr);
            lmma_pkg::OFS_TRACE_DATA: rmux = {16'h0000, tword};
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= '0;
            warn_q <= 1'b0;
            due_q <= 1'b0;
            rdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
            maintenance_warning_o <= 1'b0;
            maintenance_warning_code_o <= 12'h000;
            maintenance_due_output_o <= '0;
        end else begin
            status <= next_status;
            warn_q <= next_warn;
            due_q <= |next_due;
            rdata_o <= rd_i ? rmux : 32'h0000_0000;
            irq_o <= |(next_status & mask);
            maintenance_warning_o <= next_warn;
            maintenance_warning_code_o <= next_warn ?
                lmma_pkg::WARN_CODE : 12'h000;
            maintenance_due_output_o <= next_due;
        end
    end

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_life_range: assert property (
        life[0] <= lmma_pkg::LIFE_FULL && life[3] <= lmma_pkg::LIFE_FULL)
        else $error("life value above full scale");
    a_life_step: assert property (
        (life_dec && !wr_load && life[1] != '0)
        |=> life[1] == $past(life[1]) - 1'b1)
        else $error("life did not drop by one on event");
    a_warn_raise: assert property (
        (wen_act && any_low) |=> maintenance_warning_o
        && maintenance_warning_code_o == lmma_pkg::WARN_CODE)
        else $error("warning not raised at low life");
    a_warn_off: assert property (
        (!wen_act && !restart) |=> !wen_act ##0 !maintenance_warning_o)
        else $error("warning raised while disabled");
    a_due_closed: assert property (
        (alloc && any_low && sel_map == 4'h1 && !wen_act)
        |=> maintenance_due_output_o[0])
        else $error("due output not closed at low life");
    a_due_open: assert property (
        !any_low |=> maintenance_due_output_o == '0)
        else $error("due output closed while life is high");
    a_due_alloc: assert property (
        !alloc |=> maintenance_due_output_o == '0)
        else $error("due output driven while not allocated");
    a_post_hold: assert property (
        accept |=> tr_post [*2])
        else $error("capture did not continue after alarm");
    a_trace_refuse: assert property (
        (alm_rise && (powerup_s || util_s || tool_s || tr_post))
        |=> $stable(trig_ptr))
        else $error("trace taken for a refused alarm");
    a_low_track: assert property (
        low[2] == (life[2] <= lmma_pkg::LIFE_WARN))
        else $error("low flag out of step with life");
    a_onoff_pack: assert property (
        smp.onoff[4] == alm_s)
        else $error("alarm state missing from trace sample");

    c_trace_done: cover property (post_end ##1 tr_state == lmma_pkg::TR_HELD);
    c_warn_on: cover property (wen_act && any_low ##1 maintenance_warning_o);
    c_reject: cover property (reject);
endmodule : lmma_top

// ---- dv/lmma_host_model.sv ----
// Purpose: host controller that watches the maintenance due output
// Assumes: due lines are registered levels on mclk_i
// Notes: remembers any closed line until reset
module lmma_host_model #(
    parameter int NOUT = 3
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // observed outputs
    input wire logic [NOUT-1:0] due_i,
    output logic due_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // a host only reads the level; it never answers the block
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            due_seen_o <= 1'b0;
        end else if (|due_i) begin
            due_seen_o <= 1'b1;
        end
    end
endmodule : lmma_host_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench of the life monitor block
// Assumes: 40 MHz clock, short sample period of 4 cycles
// Notes: each scenario judges its own results
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic pwr = 1'b0;
    logic son = 1'b1;
    logic alarm = 1'b0;
    logic [2:0] busy = 3'h0;
    // traced command levels: pcon, forward limit, reverse limit, gain select
    logic [3:0] cmd = 4'hA;
    lmma_pkg::lmma_num_t num_i = '0;
    logic warn_o;
    logic [11:0] code_o;
    logic [2:0] due_o;
    logic irq_o;
    logic seen;
    logic [31:0] v;
    int err_count = 0;
    int compares = 0;
    lmma_top #(.DEPTH(16), .SAMPLE_CYC(4), .NOUT(3)) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .main_power_on_state_i(pwr), .servo_on_i(son),
        .servo_alarm_flag_i(alarm),
        .proportional_control_command_i(cmd[3]),
        .forward_torque_limit_command_i(cmd[2]),
        .reverse_torque_limit_command_i(cmd[1]),
        .gain_select_one_i(cmd[0]),
        .powerup_busy_i(busy[2]), .utility_busy_i(busy[1]),
        .tool_trace_i(busy[0]), .num_i(num_i),
        .maintenance_warning_o(warn_o),
        .maintenance_warning_code_o(code_o),
        .maintenance_due_output_o(due_o), .irq_o(irq_o)
    );
    lmma_host_model #(.NOUT(3)) host (
        .mclk_i(mclk_i), .rst_i(rst_i), .due_i(due_o), .due_seen_o(seen)
    );
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // covers two sync stages, edge detect and the output register
    task automatic settle();
        repeat (6) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic t_reset();
        rd(lmma_pkg::OFS_LIFE, v);
        check("life", 32'h6464_6464, v);
        rd(lmma_pkg::OFS_CTRL, v);
        check("ctrl", 32'h0000_0000, v);
        rd(8'h30, v);
        check("unmapped", 32'h0000_0000, v);
        check("due", 32'h0, {29'h0, due_o});
        $display("test reset done");
    endtask : t_reset
    task automatic t_life();
        wr(lmma_pkg::OFS_MASK, 32'h0000_0002);
        wr(lmma_pkg::OFS_LIFE_LOAD, 32'h0000_020B);
        pwr <= 1'b1;
        settle();
        rd(lmma_pkg::OFS_LIFE, v);
        check("life on", 32'h630A_6363, v);
        check("due unalloc", 32'h0, {29'h0, due_o});
        son <= 1'b0;
        settle();
        rd(lmma_pkg::OFS_LIFE, v);
        check("life off", 32'h6209_6262, v);
        wr(lmma_pkg::OFS_ALLOC, 32'h0000_0101);
        settle();
        check("due compat", 32'h1, {29'h0, due_o});
        check("warn off", 32'h0, {31'h0, warn_o});
        check("irq", 32'h1, {31'h0, irq_o});
        rd(lmma_pkg::OFS_STATUS, v);
        check("status due", 32'h2, v & 32'h2);
        settle();
        check("irq clr", 32'h0, {31'h0, irq_o});
        wr(lmma_pkg::OFS_ALLOC, 32'h0003_0002);
        settle();
        check("due multi", 32'h4, {29'h0, due_o});
        wr(lmma_pkg::OFS_CTRL, 32'h0000_0001);
        settle();
        check("warn stored", 32'h0, {31'h0, warn_o});
        wr(lmma_pkg::OFS_CTRL, 32'h0000_0003);
        settle();
        check("warn", 32'h1, {31'h0, warn_o});
        check("code", 32'h09B0, {20'h0, code_o});
        wr(lmma_pkg::OFS_LIFE_LOAD, 32'h0000_020B);
        settle();
        check("due 11", 32'h0, {29'h0, due_o});
        check("code 11", 32'h0, {20'h0, code_o});
        wr(lmma_pkg::OFS_LIFE_LOAD, 32'h0000_030A);
        settle();
        check("due 10", 32'h4, {29'h0, due_o});
        check("host", 32'h1, {31'h0, seen});
        $display("test life done");
    endtask : t_life
    task automatic alarm_pulse();
        alarm <= 1'b1;
        settle();
        alarm <= 1'b0;
        settle();
    endtask : alarm_pulse
    task automatic t_trace();
        num_i.bus_volt <= 16'h1234;
        for (int k = 0; k < 3; k++) begin
            rd(lmma_pkg::OFS_STATUS, v);
            busy <= 3'h1 << k;
            alarm_pulse();
            busy <= 3'h0;
            rd(lmma_pkg::OFS_STATUS, v);
            check("refused busy", 32'h8, v & 32'hC);
        end
        alarm_pulse();
        rd(lmma_pkg::OFS_TRACE, v);
        check("post", 32'h2, v & 32'h7);
        repeat (60) @(posedge mclk_i);
        rd(lmma_pkg::OFS_TRACE, v);
        check("held", 32'h4, v & 32'h7);
        rd(lmma_pkg::OFS_STATUS, v);
        check("done", 32'h4, v & 32'hC);
        alarm_pulse();
        rd(lmma_pkg::OFS_STATUS, v);
        check("refused held", 32'h8, v & 32'hC);
        wr(lmma_pkg::OFS_TRACE_ADDR, 32'h0000_0005);
        repeat (2) @(posedge mclk_i);
        rd(lmma_pkg::OFS_TRACE_DATA, v);
        check("bus volt", 32'h0000_1234, v);
        // alarm bit masked: the oldest sample may fall inside a pulse
        wr(lmma_pkg::OFS_TRACE_ADDR, 32'h0000_0006);
        repeat (2) @(posedge mclk_i);
        rd(lmma_pkg::OFS_TRACE_DATA, v);
        check("onoff", 32'h0000_004A, v & 32'h0000_006F);
        wr(lmma_pkg::OFS_TRACE, 32'h0000_0001);
        rd(lmma_pkg::OFS_TRACE, v);
        check("rearm", 32'h1, v & 32'h7);
        $display("test trace done");
    endtask : t_trace
    task automatic complete_run();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_life();
        t_trace();
        complete_run();
    end
    // the tests need well under 1000 cycles
    initial begin
        #200us;
        err_count++;
        complete_run();
    end
endmodule : testbench
